// [logic/jtag_tap_id_usercode.v]
`timescale 1ns/1ps
`include "tap_defs.vh"
module jtag_tap_id_usercode (
	clk,
	rst_n,
	tck,
	tms,
	tdi,
	trst_n,
	security_word,
	pin_in,
	tdo,
	tdo_oe,
	pin_out,
	pin_oe_ext,
	chip_tdi,
	chip_sel,
	chip_capture,
	chip_shift,
	chip_update,
	chip_tck_rise,
	chip_tdo
);
	input wire clk;
	input wire rst_n;
	input wire tck;
	input wire tms;
	input wire tdi;
	input wire trst_n;
	input wire [31:0] security_word;
	input wire [`BSR_W-1:0] pin_in;
	output reg tdo;
	output reg tdo_oe;
	output reg [`BSR_W-1:0] pin_out;
	output reg pin_oe_ext;
	output reg chip_tdi;
	output reg chip_sel;
	output reg chip_capture;
	output reg chip_shift;
	output reg chip_update;
	output reg chip_tck_rise;
	input wire chip_tdo;
	// ----------------------------------------
	// Input synchronisers and edges
	// ----------------------------------------
	reg [3:0] sync1_reg;
	reg [3:0] sync2_reg;
	reg tck_old_reg;
	reg chip_tdo1_reg;
	reg chip_tdo2_reg;
	reg [`BSR_W-1:0] pin1_reg;
	reg [`BSR_W-1:0] pin2_reg;
	wire tck_s = sync2_reg[0];
	wire tms_s = sync2_reg[1];
	wire tdi_s = sync2_reg[2];
	wire trst_s = sync2_reg[3];
	wire tck_rise = tck_s & ~tck_old_reg;
	wire tck_fall = ~tck_s & tck_old_reg;
	wire locked = security_word[`SEC_JTAG_OFF];
	wire tap_rst_n = rst_n & trst_s & ~locked;
	always @(posedge clk) begin
		if (!rst_n) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			tck_old_reg <= 1'b0;
			chip_tdo1_reg <= 1'b0;
			chip_tdo2_reg <= 1'b0;
			pin1_reg <= {`BSR_W{1'b0}};
			pin2_reg <= {`BSR_W{1'b0}};
		end else begin
			sync1_reg <= {trst_n, tdi, tms, tck};
			sync2_reg <= sync1_reg;
			tck_old_reg <= tck_s;
			chip_tdo1_reg <= chip_tdo;
			chip_tdo2_reg <= chip_tdo1_reg;
			pin1_reg <= pin_in;
			pin2_reg <= pin1_reg;
		end
	end
	// ----------------------------------------
	// TAP controller
	// ----------------------------------------
	wire [15:0] st;
	tap_fsm u_fsm (
		.clk(clk),
		.rst_n(tap_rst_n),
		.tck_rise(tck_rise),
		.tms(tms_s),
		.state_reg(st)
	);
	wire in_tlr = st[`ST_TLR];
	wire in_cdr = st[`ST_CDR];
	wire in_shdr = st[`ST_SHDR];
	wire in_udr = st[`ST_UDR];
	wire in_cir = st[`ST_CIR];
	wire in_shir = st[`ST_SHIR];
	wire in_uir = st[`ST_UIR];
	// ----------------------------------------
	// ID word and user code word (UID taken from security_word)
	// ----------------------------------------
	wire [31:0] id_word = {`ID_VERSION, `ID_PART, `ID_MFR, 1'b1};
	wire [9:0] uid = security_word[`SEC_UID_HI:`SEC_UID_LO];
	wire [31:0] user_word = {uid, `UC_REV};
	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	function ir_match;
		input [`IR_W-1:0] code;
		input [`IR_W-1:0] op;
		begin
			ir_match = code == op;
		end
	endfunction
	// ----------------------------------------
	// Instruction and data registers
	// ----------------------------------------
	reg [`IR_W-1:0] ir_sh_reg;
	reg [`IR_W-1:0] ir_reg;
	reg [`DR_W-1:0] dr_reg;
	reg [`BSR_W-1:0] bsr_reg;
	reg byp_reg;
	wire is_id = ir_match(ir_reg, `IR_IDCODE);
	wire is_uc = ir_match(ir_reg, `IR_USERCODE);
	wire is_ext = ir_match(ir_reg, `IR_EXTEST);
	wire is_bs = is_ext || ir_match(ir_reg, `IR_SAMPLE);
	wire is_chip = ir_match(ir_reg, `IR_CHIPTAP);
	reg out_bit;
	always @* begin
		if (in_shir)
			out_bit = ir_sh_reg[0];
		else if (is_id || is_uc)
			out_bit = dr_reg[0];
		else if (is_bs)
			out_bit = bsr_reg[0];
		else if (is_chip)
			out_bit = chip_tdo2_reg;
		else
			out_bit = byp_reg;
	end
	always @(posedge clk) begin
		if (!tap_rst_n) begin
			ir_sh_reg <= {`IR_W{1'b0}};
			ir_reg <= `IR_IDCODE;
			dr_reg <= {`DR_W{1'b0}};
			bsr_reg <= {`BSR_W{1'b0}};
			byp_reg <= 1'b0;
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			if (in_tlr)
				ir_reg <= `IR_IDCODE;
			if (tck_rise) begin
				if (in_cir)
					ir_sh_reg <= `IR_CAPTURE_PAT;
				if (in_shir)
					ir_sh_reg <= {tdi_s, ir_sh_reg[`IR_W-1:1]};
				if (in_cdr) begin
					byp_reg <= 1'b0;
					if (is_id)
						dr_reg <= id_word;
					if (is_uc)
						dr_reg <= user_word;
					if (is_bs)
						bsr_reg <= pin2_reg;
				end
				if (in_shdr) begin
					byp_reg <= tdi_s;
					dr_reg <= {tdi_s, dr_reg[`DR_W-1:1]};
					bsr_reg <= {tdi_s, bsr_reg[`BSR_W-1:1]};
				end
			end
			if (tck_fall) begin
				if (in_uir)
					ir_reg <= ir_sh_reg;
				tdo <= out_bit;
				tdo_oe <= in_shir | in_shdr;
			end
		end
	end
	// ----------------------------------------
	// Inner chip TAP forwarding
	// ----------------------------------------
	always @(posedge clk) begin
		if (!tap_rst_n) begin
			chip_tdi <= 1'b0;
			chip_sel <= 1'b0;
			chip_capture <= 1'b0;
			chip_shift <= 1'b0;
			chip_update <= 1'b0;
			chip_tck_rise <= 1'b0;
		end else begin
			chip_tck_rise <= tck_rise & is_chip;
			chip_sel <= is_chip;
			chip_capture <= is_chip & in_cdr;
			chip_shift <= is_chip & in_shdr;
			chip_update <= is_chip & in_udr;
			chip_tdi <= tdi_s;
		end
	end
	// ----------------------------------------
	// Boundary pin drivers
	// ----------------------------------------
	always @(posedge clk) begin
		if (!tap_rst_n) begin
			pin_out <= {`BSR_W{1'b0}};
			pin_oe_ext <= 1'b0;
		end else if (!is_ext) begin
			pin_oe_ext <= 1'b0;
		end else if (tck_fall && in_udr) begin
			pin_out <= bsr_reg;
			pin_oe_ext <= 1'b1;
		end
	end
endmodule

// [logic/tap_defs.vh]
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH
`define IR_W 4
`define DR_W 32
`define TMS_RESET_COUNT 3'h5
`define CNT_W 3
`define IR_BYPASS 4'hF
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h1
`define IR_IDCODE 4'h2
`define IR_USERCODE 4'h3
`define IR_CHIPTAP 4'h4
`define IR_CAPTURE_PAT 4'h1
`define ID_VERSION 4'h0
`define ID_PART 16'h0001
`define ID_MFR 11'h001
`define UC_UID_HI 31
`define UC_UID_LO 22
`define SEC_UID_HI 31
`define SEC_UID_LO 22
`define SEC_JTAG_OFF 0
`define UC_REV 22'h000000
`define BSR_W 8
`define ST_TLR 0
`define ST_CDR 3
`define ST_SHDR 4
`define ST_UDR 8
`define ST_CIR 10
`define ST_SHIR 11
`define ST_UIR 15
`endif

// [logic/tap_fsm.v]
`timescale 1ns/1ps
`include "tap_defs.vh"
module tap_fsm (
	clk,
	rst_n,
	tck_rise,
	tms,
	state_reg
);
	input wire clk;
	input wire rst_n;
	input wire tck_rise;
	input wire tms;
	output reg [15:0] state_reg;
	// ----------------------------------------
	// One-hot TAP states
	// ----------------------------------------
	localparam S_TLR = 16'h0001;
	localparam S_RTI = 16'h0002;
	localparam S_SDR = 16'h0004;
	localparam S_CDR = 16'h0008;
	localparam S_SHDR = 16'h0010;
	localparam S_E1DR = 16'h0020;
	localparam S_PDR = 16'h0040;
	localparam S_E2DR = 16'h0080;
	localparam S_UDR = 16'h0100;
	localparam S_SIR = 16'h0200;
	localparam S_CIR = 16'h0400;
	localparam S_SHIR = 16'h0800;
	localparam S_E1IR = 16'h1000;
	localparam S_PIR = 16'h2000;
	localparam S_E2IR = 16'h4000;
	localparam S_UIR = 16'h8000;
	reg [15:0] state_next;
	reg [`CNT_W-1:0] ones_reg;
	reg [`CNT_W-1:0] ones_next;
	always @* begin
		ones_next = ones_reg;
		if (tck_rise) begin
			if (!tms)
				ones_next = {`CNT_W{1'b0}};
			else if (ones_reg != `TMS_RESET_COUNT)
				ones_next = ones_reg + 3'h1;
		end
	end
	always @* begin
		state_next = state_reg;
		if (tck_rise) begin
			case (state_reg)
			S_TLR: state_next = tms ? S_TLR : S_RTI;
			S_RTI: state_next = tms ? S_SDR : S_RTI;
			S_SDR: state_next = tms ? S_SIR : S_CDR;
			S_CDR: state_next = tms ? S_E1DR : S_SHDR;
			S_SHDR: state_next = tms ? S_E1DR : S_SHDR;
			S_E1DR: state_next = tms ? S_UDR : S_PDR;
			S_PDR: state_next = tms ? S_E2DR : S_PDR;
			S_E2DR: state_next = tms ? S_UDR : S_SHDR;
			S_UDR: state_next = tms ? S_SDR : S_RTI;
			S_SIR: state_next = tms ? S_TLR : S_CIR;
			S_CIR: state_next = tms ? S_E1IR : S_SHIR;
			S_SHIR: state_next = tms ? S_E1IR : S_SHIR;
			S_E1IR: state_next = tms ? S_UIR : S_PIR;
			S_PIR: state_next = tms ? S_E2IR : S_PIR;
			S_E2IR: state_next = tms ? S_UIR : S_SHIR;
			S_UIR: state_next = tms ? S_SDR : S_RTI;
			default: state_next = S_TLR;
			endcase
			if (tms && ones_reg == `TMS_RESET_COUNT - 3'h1)
				state_next = S_TLR;
		end
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= S_TLR;
			ones_reg <= {`CNT_W{1'b0}};
		end else begin
			state_reg <= state_next;
			ones_reg <= ones_next;
		end
	end
endmodule

// [tb/jtag_host.sv]
`timescale 1ns/1ps
module jtag_host (
	output reg tck = 1'b0,
	output reg tms = 1'b1,
	output reg tdi = 1'b0,
	input wire tdo,
	input wire tdo_oe
);
	reg o;
	integer i;
	task step(input t, input d);
	begin
		tms = t;
		tdi = d;
		#24 tck = 1'b1;
		// Released line reads high through its pull-up
		o = tdo_oe ? tdo : 1'b1;
		#24 tck = 1'b0;
	end
	endtask
	task reset;
	begin
		for (i = 0; i < 6; i = i + 1)
			step(i < 5, 1'b0);
	end
	endtask
	task scan(input ir, input integer n, input [31:0] din, output [31:0] dout);
	begin
		dout = 32'h0;
		step(1'b1, 1'b0);
		if (ir)
			step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		for (i = 0; i < n; i = i + 1) begin
			step(i == n - 1, din[i]);
			dout[i] = o;
		end
		step(1'b1, ~din[n - 1]);
		step(1'b0, ~din[n - 1]);
	end
	endtask
endmodule

// [tb/jtag_tap_id_usercode_bench.sv]
`timescale 1ns/1ps
`include "tap_defs.vh"
module jtag_tap_id_usercode_bench;
	localparam [31:0] id_word = {`ID_VERSION, `ID_PART, `ID_MFR, 1'b1};
	reg clk, rst_n;
	reg [31:0] security_word, r;
	wire tck, tms, tdi, tdo, tdo_oe, pin_oe_ext, chip_tdi, chip_sel;
	wire [`BSR_W-1:0] pin_out;
	integer num_errors, checks;
	jtag_tap_id_usercode i_dut (.clk, .rst_n, .tck, .tms, .tdi, .trst_n(1'b1), .security_word,
		.pin_in(8'hA5), .tdo, .tdo_oe, .pin_out, .pin_oe_ext, .chip_tdi, .chip_sel,
		.chip_capture(), .chip_shift(), .chip_update(), .chip_tck_rise(), .chip_tdo(chip_tdi));
	jtag_host h (.tck, .tms, .tdi, .tdo, .tdo_oe);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task chk(input [31:0] got, input [31:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t got %h", $time, got);
		end
	end
	endtask
	task final_report;
	begin
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	task t_id;
	begin
		h.reset;
		h.scan(0, 32, 32'h0, r);
		chk(r, id_word);
		h.scan(1, 4, `IR_BYPASS, r);
		chk(r, `IR_CAPTURE_PAT);
		h.scan(0, 8, 32'h3C, r);
		chk(r, 32'h78);
		$display("id end");
	end
	endtask
	task t_uc;
	begin
		@(negedge clk) security_word = 32'hA9400000;
		h.scan(1, 4, `IR_USERCODE, r);
		h.scan(0, 32, 32'h0, r);
		chk(r, {security_word[`SEC_UID_HI:`SEC_UID_LO], `UC_REV});
		@(negedge clk) security_word = 32'h0;
		h.scan(0, 32, 32'h0, r);
		chk(r, 32'h0);
		h.reset;
		h.scan(0, 32, 32'h0, r);
		chk(r, id_word);
		$display("uc end");
	end
	endtask
	task t_io;
	begin
		h.scan(1, 4, `IR_SAMPLE, r);
		h.scan(0, `BSR_W, 32'h0, r);
		chk(r, 32'hA5);
		h.scan(1, 4, `IR_EXTEST, r);
		h.scan(0, `BSR_W, 32'h5A, r);
		chk(r, 32'hA5);
		chk({24'h0, pin_out}, 32'h5A);
		chk({31'h0, pin_oe_ext}, 32'h1);
		h.scan(1, 4, `IR_CHIPTAP, r);
		chk({31'h0, pin_oe_ext}, 32'h0);
		chk({31'h0, chip_sel}, 32'h1);
		h.scan(0, 8, 32'h3C, r);
		chk(r, 32'h78);
		$display("io end");
	end
	endtask
	task t_lock;
	begin
		@(negedge clk) security_word = 32'h1;
		h.scan(0, 32, 32'h0, r);
		chk(r, 32'hFFFFFFFF);
		@(negedge clk) security_word = 32'h0;
		h.reset;
		$display("lock end");
	end
	endtask
	initial begin
		num_errors = 0;
		checks = 0;
		rst_n = 1'b0;
		security_word = 32'h0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_id;
		t_uc;
		t_io;
		t_lock;
		final_report;
	end
	initial begin
		#100000;
		num_errors = num_errors + 1;
		final_report;
	end
endmodule

// [tb/jtag_tap_id_usercode_properties.sv]
`timescale 1ns/1ps
module jtag_tap_chk (
	input wire clk,
	input wire rst_n,
	input wire tck,
	input wire [31:0] security_word,
	input wire tdo,
	input wire tdo_oe,
	input wire chip_sel,
	input wire chip_capture,
	input wire chip_shift,
	input wire chip_update,
	input wire chip_tck_rise
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_LOCK_OE: assert property (security_word[0] [*4] |-> !tdo_oe) else $error("oe");
	AST_LOCK_CS: assert property (security_word[0] [*4] |-> !chip_sel) else $error("cs");
	AST_TDO_FALL: assert property ($changed(tdo) |-> !tck) else $error("tdo");
	AST_RISE_TCK: assert property (chip_tck_rise |-> tck) else $error("rise");
	AST_RISE_ONE: assert property (chip_tck_rise |=> !chip_tck_rise) else $error("pulse");
	AST_CAP_SHF: assert property (!(chip_capture && chip_shift)) else $error("c s");
	AST_CAP_UPD: assert property (!(chip_capture && chip_update)) else $error("c u");
	AST_UPD_OE: assert property (chip_update |-> !tdo_oe) else $error("u oe");
endmodule
bind jtag_tap_id_usercode jtag_tap_chk i_chk (.clk, .rst_n, .tck, .security_word, .tdo,
	.tdo_oe, .chip_sel, .chip_capture, .chip_shift, .chip_update, .chip_tck_rise);
